// *** bench/cmp_analog_model.sv ***
// behavioural model of the two analog comparator cores
`timescale 1ns/1ps
module cmp_analog_model (
  input wire logic cmp_a_enable,
  input wire logic cmp_b_enable,
  input wire logic cmp_a_use_internal_ref,
  input wire logic cmp_b_use_internal_ref,
  input wire logic [1:0] ref_level_select,
  input wire logic [11:0] pos_a,
  input wire logic [11:0] neg_a,
  input wire logic [11:0] pos_b,
  input wire logic [11:0] neg_b,
  output logic cmp_a_raw,
  output logic cmp_b_raw
);
  // levels in millivolts: 900 plus 100 a step
  logic [11:0] ref_mv;
  assign ref_mv = 12'h384 + 12'h064 * 12'(ref_level_select);
  // a powered-down core holds its output low; the delay keeps the
  // analog edge clear of the clock edge
  assign #2 cmp_a_raw = cmp_a_enable &&
    ((cmp_a_use_internal_ref ? ref_mv : pos_a) > neg_a);
  assign #2 cmp_b_raw = cmp_b_enable &&
    ((cmp_b_use_internal_ref ? ref_mv : pos_b) > neg_b);
endmodule

// *** bench/cmp_ctrl_checker.sv ***
// assertion checker for the dual comparator control block
`timescale 1ns/1ps
module cmp_ctrl_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic cmp_a_raw,
  input wire logic cmp_a_enable,
  input wire logic cmp_a_use_internal_ref,
  input wire logic [1:0] ref_level_select,
  input wire logic [3:0] ref_tap_sel,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_a_gpio_o,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_a_gpio_oe,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_a_pin_o,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_a_pin_oe,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_a_analog_sel,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic rd_a;
  logic rd_b;
  assign rd_a = s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h270;
  assign rd_b = s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h274;
  property p_pos_pin;
    cmp_a_analog_sel.pos == (cmp_a_enable && !cmp_a_use_internal_ref);
  endproperty
  a_pos_pin: assert property (p_pos_pin)
    else $error("positive pin steering wrong");
  property p_neg_pin;
    cmp_a_analog_sel.neg == cmp_a_enable;
  endproperty
  a_neg_pin: assert property (p_neg_pin)
    else $error("negative pin steering wrong");
  property p_out_drive;
    cmp_a_analog_sel.out |-> cmp_a_pin_oe.out && cmp_a_enable;
  endproperty
  a_out_drive: assert property (p_out_drive)
    else $error("output pin not driven");
  property p_gpio_off;
    !cmp_a_enable |-> cmp_a_analog_sel == 3'h0 &&
      cmp_a_pin_o == cmp_a_gpio_o && cmp_a_pin_oe == cmp_a_gpio_oe;
  endproperty
  a_gpio_off: assert property (p_gpio_off)
    else $error("disabled comparator holds a pin");
  property p_pos_free;
    cmp_a_use_internal_ref |-> cmp_a_pin_o.pos == cmp_a_gpio_o.pos &&
      cmp_a_pin_oe.pos == cmp_a_gpio_oe.pos;
  endproperty
  a_pos_free: assert property (p_pos_free)
    else $error("positive pin not released");
  property p_tap;
    ref_tap_sel == 4'h1 << ref_level_select;
  endproperty
  a_tap: assert property (p_tap)
    else $error("reference tap decode wrong");
  property p_buffer;
    (cmp_a_analog_sel.out && $stable(cmp_a_raw))[*6] |->
      cmp_a_pin_o.out == cmp_a_raw;
  endproperty
  a_buffer: assert property (p_buffer)
    else $error("output pin does not follow result");
  property p_live;
    ($stable(cmp_a_raw)[*6] ##0 rd_a) |=>
      s_axi_rdata[2] == $past(cmp_a_raw);
  endproperty
  a_live: assert property (p_live)
    else $error("result flag not live");
  property p_reg_b_low;
    rd_b |=> s_axi_rdata[1:0] == 2'h0;
  endproperty
  a_reg_b_low: assert property (p_reg_b_low)
    else $error("second register low bits not zero");
  property p_reset;
    $past(srst) |-> !cmp_a_enable && ref_level_select == 2'h0 && !irq;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");
  c_irq: cover property ($rose(irq));
  c_drive: cover property (cmp_a_analog_sel.out && cmp_a_pin_o.out);
  c_read: cover property (rd_a);
endmodule
bind cmp_ctrl_top cmp_ctrl_checker #(.ADDR_W(ADDR_W)) cmp_ctrl_checker_i (
  .ref_clk, .srst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .cmp_a_raw, .cmp_a_enable, .cmp_a_use_internal_ref,
  .ref_level_select, .ref_tap_sel, .cmp_a_gpio_o, .cmp_a_gpio_oe,
  .cmp_a_pin_o, .cmp_a_pin_oe, .cmp_a_analog_sel, .irq);

// *** bench/dual_comparator_control_bench.sv ***
// self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`include "cmp_ctrl_cfg.svh"
module dual_comparator_control_bench;
  localparam logic [11:0] A_ADR = `CMP_A_CTRL_IDX * 4;
  localparam logic [11:0] B_ADR = `CMP_B_CTRL_IDX * 4;
  localparam logic [11:0] ST_ADR = `EVT_STATUS_IDX * 4;
  localparam logic [11:0] MK_ADR = `EVT_MASK_IDX * 4;
  localparam logic [11:0] ADRS [4] = '{A_ADR, B_ADR, ST_ADR, MK_ADR};
  localparam logic [1:0] OK = `AXI_RESP_OKAY;
  localparam logic [1:0] SLV = `AXI_RESP_SLVERR;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmp_a_raw, cmp_b_raw, cmp_a_enable, cmp_b_enable;
  logic cmp_a_use_internal_ref, cmp_b_use_internal_ref, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, ref_level_select;
  logic [3:0] ref_tap_sel;
  logic [31:0] s_axi_rdata, d;
  cmp_ctrl_pkg::pin_trio_t cmp_a_gpio_o = 3'h5, cmp_a_gpio_oe = 3'h3;
  cmp_ctrl_pkg::pin_trio_t cmp_b_gpio_o = 3'h2, cmp_b_gpio_oe = 3'h6;
  cmp_ctrl_pkg::pin_trio_t cmp_a_pin_o, cmp_a_pin_oe, cmp_a_analog_sel;
  cmp_ctrl_pkg::pin_trio_t cmp_b_pin_o, cmp_b_pin_oe, cmp_b_analog_sel;
  logic [11:0] pos_a = 12'h0, neg_a = 12'h0, pos_b = 12'h0, neg_b = 12'h0;
  int err_total = 0;
  int checked = 0;
  cmp_ctrl_top #(.ADDR_W(12)) cmp_ctrl_top_i (.ref_clk, .srst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cmp_a_raw, .cmp_b_raw, .cmp_a_enable, .cmp_b_enable,
    .cmp_a_use_internal_ref, .cmp_b_use_internal_ref, .ref_level_select,
    .ref_tap_sel, .cmp_a_gpio_o, .cmp_a_gpio_oe, .cmp_a_pin_o,
    .cmp_a_pin_oe, .cmp_a_analog_sel, .cmp_b_gpio_o, .cmp_b_gpio_oe,
    .cmp_b_pin_o, .cmp_b_pin_oe, .cmp_b_analog_sel, .irq);
  cmp_analog_model cmp_analog_model_i (.cmp_a_enable, .cmp_b_enable,
    .cmp_a_use_internal_ref, .cmp_b_use_internal_ref, .ref_level_select,
    .pos_a, .neg_a, .pos_b, .neg_b, .cmp_a_raw, .cmp_b_raw);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'h0;
    check(32'(s_axi_bvalid), 32'h1);
    check(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er,
      output logic [31:0] v);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    check(32'(s_axi_rvalid), 32'h1);
    check(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] v;
    rd(a, OK, v);
    check(v & m, e);
  endtask
  // c holds enable, drive enable, internal reference
  task automatic pins(input logic [2:0] c, input logic [2:0] as, po, oe,
      go, goe);
    logic [2:0] s;
    s = {c[2] & !c[0], c[2], c[2] & c[1]};
    check(32'(as), 32'(s));
    check(32'(oe), 32'((goe & ~s) | {2'h0, s[0]}));
    check(32'(po & ~s), 32'(go & ~s));
  endtask
  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'h0;
    for (int i = 0; i < 4; i++) rdm(ADRS[i], 32'hffffffff, 32'h0);
    wr(12'h3f0, 32'h0, SLV);
    rd(12'h3f0, SLV, d);
    check(d, 32'h0);
    s_axi_wstrb <= 4'h0;
    wr(MK_ADR, 32'h3, OK);
    s_axi_wstrb <= 4'h1;
    rdm(MK_ADR, 32'hffffffff, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wr(A_ADR, 32'({k[2], 2'h0, k[1:0], 3'h0}), OK);
      wr(B_ADR, 32'({k[2], 2'h0, k[1:0], 3'h0}), OK);
      pins(k[2:0], cmp_a_analog_sel, cmp_a_pin_o, cmp_a_pin_oe,
        cmp_a_gpio_o, cmp_a_gpio_oe);
      pins(k[2:0], cmp_b_analog_sel, cmp_b_pin_o, cmp_b_pin_oe,
        cmp_b_gpio_o, cmp_b_gpio_oe);
      check(32'({cmp_a_enable, cmp_a_use_internal_ref, cmp_b_enable,
        cmp_b_use_internal_ref}), 32'({2{k[2], k[2] & k[0]}}));
    end
    neg_a <= 12'h3b6;
    neg_b <= 12'h41a;
    for (int c = 0; c < 4; c++) begin
      wr(A_ADR, 32'h88 | c, OK);
      wr(B_ADR, 32'h8b, OK);
      settle();
      rdm(A_ADR, 32'h7, 32'({c > 0, 2'(c)}));
      rdm(B_ADR, 32'h7, 32'({c > 1, 2'h0}));
      check(32'(ref_tap_sel), 32'h1 << c);
    end
    wr(A_ADR, 32'h0, OK);
    wr(B_ADR, 32'h0, OK);
    wr(MK_ADR, 32'h3, OK);
    pos_a <= 12'h3e8;
    neg_a <= 12'h1f4;
    wr(A_ADR, 32'hd0, OK);
    settle();
    rdm(A_ADR, 32'h24, 32'h24);
    check(32'(cmp_a_pin_o.out), 32'h1);
    check(32'(irq), 32'h1);
    pos_a <= 12'h190;
    settle();
    rdm(A_ADR, 32'h24, 32'h20);
    rdm(ST_ADR, 32'h3, 32'h1);
    check(32'(irq), 32'h0);
    wr(A_ADR, 32'hd0, OK);
    rdm(A_ADR, 32'h20, 32'h0);
    wr(MK_ADR, 32'h0, OK);
    pos_a <= 12'h3e8;
    settle();
    check(32'(irq), 32'h0);
    rdm(ST_ADR, 32'h3, 32'h1);
    pos_a <= 12'h190;
    settle();
    wr(A_ADR, 32'h90, OK);
    wr(MK_ADR, 32'h3, OK);
    pos_a <= 12'h3e8;
    settle();
    rdm(A_ADR, 32'h20, 32'h20);
    rdm(ST_ADR, 32'h3, 32'h0);
    check(32'(irq), 32'h0);
    end_of_test();
  end
endmodule

// *** hdl/cmp_channel.sv ***
// pin steering and result capture for one comparator
`timescale 1ns/1ps
module cmp_channel (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic use_internal_ref,
  input wire logic drive_enable,
  input wire logic cmp_raw,
  input wire cmp_ctrl_pkg::pin_trio_t gpio_o,
  input wire cmp_ctrl_pkg::pin_trio_t gpio_oe,
  output cmp_ctrl_pkg::pin_trio_t pin_o,
  output cmp_ctrl_pkg::pin_trio_t pin_oe,
  output cmp_ctrl_pkg::pin_trio_t analog_sel,
  output logic result
);

  logic out_buf;

  cmp_sync3 u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(cmp_raw),
    .sync_out(result)
  );

  // the pin sees a digital copy, never the analog stage itself
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_buf <= 1'b0;
    end else begin
      out_buf <= result;
    end
  end

  always_comb begin
    analog_sel.pos = enable && !use_internal_ref;
    analog_sel.neg = enable;
    analog_sel.out = enable && drive_enable;
    // any pin not claimed above stays with general-purpose I/O
    pin_o.pos = gpio_o.pos;
    pin_oe.pos = analog_sel.pos ? 1'b0 : gpio_oe.pos;
    pin_o.neg = gpio_o.neg;
    pin_oe.neg = analog_sel.neg ? 1'b0 : gpio_oe.neg;
    pin_o.out = analog_sel.out ? out_buf : gpio_o.out;
    pin_oe.out = analog_sel.out ? 1'b1 : gpio_oe.out;
  end

endmodule

// *** hdl/cmp_ctrl_cfg.svh ***
// register map, field positions, reset values and encodings
`ifndef CMP_CTRL_CFG_SVH
`define CMP_CTRL_CFG_SVH

// register indices; byte address is four times the index
`define CMP_A_CTRL_IDX 10'h09c
`define CMP_B_CTRL_IDX 10'h09d
`define EVT_STATUS_IDX 10'h0a0
`define EVT_MASK_IDX 10'h0a1

// control register fields
`define CTRL_ENABLE_BIT 7
`define CTRL_INT_ENABLE_BIT 6
`define CTRL_INT_REQUEST_BIT 5
`define CTRL_DRIVE_ENABLE_BIT 4
`define CTRL_INT_REF_BIT 3
`define CTRL_LIVE_RESULT_BIT 2
`define CTRL_REF_LEVEL_HI 1
`define CTRL_REF_LEVEL_LO 0

`define CMP_A_CTRL_RESET 8'h00
`define CMP_B_CTRL_RESET 8'h00
`define EVT_STATUS_RESET 2'h0
`define EVT_MASK_RESET 2'h0

// bits of the second control register that hold state
`define CMP_B_CTRL_MASK 8'hfc

// reference level codes: 0.9 V, 1.0 V, 1.1 V, 1.2 V
`define REF_LEVEL_0V9 2'h0
`define REF_LEVEL_1V0 2'h1
`define REF_LEVEL_1V1 2'h2
`define REF_LEVEL_1V2 2'h3

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// *** hdl/cmp_ctrl_pkg.sv ***
// types shared by the comparator control block
package cmp_ctrl_pkg;

  typedef struct packed {
    logic enable;
    logic int_enable;
    logic int_request;
    logic drive_enable;
    logic use_internal_ref;
    logic live_result;
    logic [1:0] ref_level_select;
  } ctrl_t;

  // one bit for each of the three shared pins of a comparator
  typedef struct packed {
    logic pos;
    logic neg;
    logic out;
  } pin_trio_t;

endpackage

// *** hdl/cmp_ctrl_top.sv ***
// dual comparator control with an axi4-lite register slave
//
// Summary of operation
// - positive pin used when enabled, external reference
// - negative pin analog whenever comparator enabled
// - output pin driven when enabled and drive-enabled
// - all other cases leave pins as GPIO
// - disabled comparator returns every pin to GPIO
// - internal reference frees positive pin to GPIO
// - bits 1:0 of first register select reference
// - codes 00..11 give 0.9, 1.0, 1.1, 1.2 V
// - bit 2 read-only result, 1 when positive higher
// - result bit follows comparator live, unlatched
// - bit 5 latches high result until cleared
// - bit 6 gates request forwarding to interrupt
// - output pin fed through internal digital buffer
// - second register lacks bits 1:0, shares reference
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "cmp_ctrl_cfg.svh"
module cmp_ctrl_top #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog comparator cores
  input wire logic cmp_a_raw,
  input wire logic cmp_b_raw,
  output logic cmp_a_enable,
  output logic cmp_b_enable,
  output logic cmp_a_use_internal_ref,
  output logic cmp_b_use_internal_ref,
  output logic [1:0] ref_level_select,
  output logic [3:0] ref_tap_sel,
  // shared pins: positive input, negative input, output
  input wire cmp_ctrl_pkg::pin_trio_t cmp_a_gpio_o,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_a_gpio_oe,
  output cmp_ctrl_pkg::pin_trio_t cmp_a_pin_o,
  output cmp_ctrl_pkg::pin_trio_t cmp_a_pin_oe,
  output cmp_ctrl_pkg::pin_trio_t cmp_a_analog_sel,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_b_gpio_o,
  input wire cmp_ctrl_pkg::pin_trio_t cmp_b_gpio_oe,
  output cmp_ctrl_pkg::pin_trio_t cmp_b_pin_o,
  output cmp_ctrl_pkg::pin_trio_t cmp_b_pin_oe,
  output cmp_ctrl_pkg::pin_trio_t cmp_b_analog_sel,
  output logic irq
);

  localparam logic [ADDR_W-1:0] CMP_A_ADDR =
    ADDR_W'({`CMP_A_CTRL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] CMP_B_ADDR =
    ADDR_W'({`CMP_B_CTRL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR =
    ADDR_W'({`EVT_STATUS_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] EVT_MASK_ADDR =
    ADDR_W'({`EVT_MASK_IDX, 2'b00});
  localparam cmp_ctrl_pkg::ctrl_t A_INIT = `CMP_A_CTRL_RESET;
  localparam cmp_ctrl_pkg::ctrl_t B_INIT = `CMP_B_CTRL_RESET;

  cmp_ctrl_pkg::ctrl_t cmp_a_ctrl;
  cmp_ctrl_pkg::ctrl_t cmp_b_ctrl;
  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic cmp_a_live_result;
  logic cmp_b_live_result;
  logic [1:0] fwd_prev;
  logic [1:0] fwd_now;

  // write channel state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic wr_a;
  logic wr_b;
  logic wr_mask;
  logic wr_hit;

  // read channel state
  logic rd_take;
  logic [31:0] next_rdata;
  logic rd_hit;
  logic rd_status;

  // ---------------------------------------------------------------
  // write path: address and data are taken in either order
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // only byte lane 0 carries register bits; other lanes are ignored
  always_comb begin
    wr_a = do_write && w_lane0 && (aw_addr == CMP_A_ADDR);
    wr_b = do_write && w_lane0 && (aw_addr == CMP_B_ADDR);
    wr_mask = do_write && w_lane0 && (aw_addr == EVT_MASK_ADDR);
    wr_hit = (aw_addr == CMP_A_ADDR) || (aw_addr == CMP_B_ADDR) ||
      (aw_addr == EVT_MASK_ADDR) || (aw_addr == EVT_STATUS_ADDR);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_a_ctrl.enable <= A_INIT.enable;
      cmp_a_ctrl.int_enable <= A_INIT.int_enable;
      cmp_a_ctrl.drive_enable <= A_INIT.drive_enable;
      cmp_a_ctrl.use_internal_ref <= A_INIT.use_internal_ref;
      cmp_a_ctrl.ref_level_select <= A_INIT.ref_level_select;
    end else if (wr_a) begin
      cmp_a_ctrl.enable <= w_byte[`CTRL_ENABLE_BIT];
      cmp_a_ctrl.int_enable <= w_byte[`CTRL_INT_ENABLE_BIT];
      cmp_a_ctrl.drive_enable <= w_byte[`CTRL_DRIVE_ENABLE_BIT];
      cmp_a_ctrl.use_internal_ref <= w_byte[`CTRL_INT_REF_BIT];
      cmp_a_ctrl.ref_level_select <=
        w_byte[`CTRL_REF_LEVEL_HI:`CTRL_REF_LEVEL_LO];
    end
  end

  // the second register keeps no reference field of its own
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_b_ctrl.enable <= B_INIT.enable;
      cmp_b_ctrl.int_enable <= B_INIT.int_enable;
      cmp_b_ctrl.drive_enable <= B_INIT.drive_enable;
      cmp_b_ctrl.use_internal_ref <= B_INIT.use_internal_ref;
    end else if (wr_b) begin
      cmp_b_ctrl.enable <= w_byte[`CTRL_ENABLE_BIT];
      cmp_b_ctrl.int_enable <= w_byte[`CTRL_INT_ENABLE_BIT];
      cmp_b_ctrl.drive_enable <= w_byte[`CTRL_DRIVE_ENABLE_BIT];
      cmp_b_ctrl.use_internal_ref <= w_byte[`CTRL_INT_REF_BIT];
    end
  end

  // ---------------------------------------------------------------
  // latched request flags: a high result while enabled sets the flag,
  // and the set beats a software clear landing in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_a_ctrl.int_request <= A_INIT.int_request;
    end else if (cmp_a_ctrl.enable && cmp_a_live_result) begin
      cmp_a_ctrl.int_request <= 1'b1;
    end else if (wr_a) begin
      // hardware never drops the flag; only software does
      cmp_a_ctrl.int_request <= w_byte[`CTRL_INT_REQUEST_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_b_ctrl.int_request <= B_INIT.int_request;
    end else if (cmp_b_ctrl.enable && cmp_b_live_result) begin
      cmp_b_ctrl.int_request <= 1'b1;
    end else if (wr_b) begin
      cmp_b_ctrl.int_request <= w_byte[`CTRL_INT_REQUEST_BIT];
    end
  end

  // the struct copies of the live result are unused; the read mux
  // takes the synchronised result directly
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_a_ctrl.live_result <= A_INIT.live_result;
      cmp_b_ctrl.live_result <= B_INIT.live_result;
      cmp_b_ctrl.ref_level_select <= B_INIT.ref_level_select;
    end else begin
      cmp_a_ctrl.live_result <= cmp_a_live_result;
      cmp_b_ctrl.live_result <= cmp_b_live_result;
      cmp_b_ctrl.ref_level_select <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // comparator channels
  // ---------------------------------------------------------------
  cmp_channel u_cmp_a (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(cmp_a_ctrl.enable),
    .use_internal_ref(cmp_a_ctrl.use_internal_ref),
    .drive_enable(cmp_a_ctrl.drive_enable),
    .cmp_raw(cmp_a_raw),
    .gpio_o(cmp_a_gpio_o),
    .gpio_oe(cmp_a_gpio_oe),
    .pin_o(cmp_a_pin_o),
    .pin_oe(cmp_a_pin_oe),
    .analog_sel(cmp_a_analog_sel),
    .result(cmp_a_live_result)
  );

  cmp_channel u_cmp_b (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(cmp_b_ctrl.enable),
    .use_internal_ref(cmp_b_ctrl.use_internal_ref),
    .drive_enable(cmp_b_ctrl.drive_enable),
    .cmp_raw(cmp_b_raw),
    .gpio_o(cmp_b_gpio_o),
    .gpio_oe(cmp_b_gpio_oe),
    .pin_o(cmp_b_pin_o),
    .pin_oe(cmp_b_pin_oe),
    .analog_sel(cmp_b_analog_sel),
    .result(cmp_b_live_result)
  );

  always_comb begin
    cmp_a_enable = cmp_a_ctrl.enable;
    cmp_b_enable = cmp_b_ctrl.enable;
    cmp_a_use_internal_ref = cmp_a_ctrl.enable &&
      cmp_a_ctrl.use_internal_ref;
    cmp_b_use_internal_ref = cmp_b_ctrl.enable &&
      cmp_b_ctrl.use_internal_ref;
    // one reference serves both comparators
    ref_level_select = cmp_a_ctrl.ref_level_select;
  end

  // one-hot tap for the reference ladder; bit 0 is the lowest level
  always_comb begin
    unique case (cmp_a_ctrl.ref_level_select)
      `REF_LEVEL_0V9: ref_tap_sel = 4'h1;
      `REF_LEVEL_1V0: ref_tap_sel = 4'h2;
      `REF_LEVEL_1V1: ref_tap_sel = 4'h4;
      `REF_LEVEL_1V2: ref_tap_sel = 4'h8;
    endcase
  end

  // ---------------------------------------------------------------
  // interrupt events: a forwarded request rising sets a sticky bit
  // ---------------------------------------------------------------
  always_comb begin
    fwd_now[0] = cmp_a_ctrl.int_request && cmp_a_ctrl.int_enable;
    fwd_now[1] = cmp_b_ctrl.int_request && cmp_b_ctrl.int_enable;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fwd_prev <= 2'h0;
    end else begin
      fwd_prev <= fwd_now;
    end
  end

  // a read of the status register clears it, but a new event wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_status <= `EVT_STATUS_RESET;
    end else begin
      evt_status <= ((rd_take && rd_status) ? 2'h0 : evt_status) |
        (fwd_now & ~fwd_prev);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_mask <= `EVT_MASK_RESET;
    end else if (wr_mask) begin
      evt_mask <= w_byte[1:0];
    end
  end

  assign irq = |(evt_status & evt_mask);

  // ---------------------------------------------------------------
  // read path: one request at a time, answer on the next edge
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_status = (s_axi_araddr == EVT_STATUS_ADDR);

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == CMP_A_ADDR) begin
      next_rdata[7:0] = {cmp_a_ctrl.enable, cmp_a_ctrl.int_enable,
        cmp_a_ctrl.int_request, cmp_a_ctrl.drive_enable,
        cmp_a_ctrl.use_internal_ref, cmp_a_live_result,
        cmp_a_ctrl.ref_level_select};
    end else if (s_axi_araddr == CMP_B_ADDR) begin
      next_rdata[7:0] = {cmp_b_ctrl.enable, cmp_b_ctrl.int_enable,
        cmp_b_ctrl.int_request, cmp_b_ctrl.drive_enable,
        cmp_b_ctrl.use_internal_ref, cmp_b_live_result,
        cmp_b_ctrl.ref_level_select};
    end else if (rd_status) begin
      next_rdata[1:0] = evt_status;
    end else if (s_axi_araddr == EVT_MASK_ADDR) begin
      next_rdata[1:0] = evt_mask;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** hdl/cmp_sync3.sv ***
// three-stage synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module cmp_sync3 (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a result that is still moving between stages keeps the old value
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_out <= 1'b0;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end

endmodule
